// ### verif/testbench.sv
// Self-checking testbench for the cycle configuration and comparator clear block.
`timescale 1ns/1ns
`include "pcacc_defs.svh"
module testbench
    import pcacc_pkg::*;
;
    logic        CORE_CLK;
    logic        RSTN;
    pcacc_byte_t SFR_ADDR;
    pcacc_byte_t SFR_WDATA;
    logic        SFR_WE;
    logic [7:0]  SFR_RDATA;
    logic [15:0] COUNTER;
    logic        COUNTER_TICK;
    logic        CMP_RESULT;
    logic [15:0] RELOAD_VALUE;
    logic        RELOAD_APPLY;
    logic [1:0]  CYCLE_LENGTH;
    logic        CH0_FREQ_MODE;
    logic        CH0_WIDE_PWM;
    logic [7:0]  CH0_MODE;
    logic [2:0]  CHAN_CLEAR;
    logic        IRQ;
    int          bad_count;
    int          n_compared;
    int          seed;
    pcacc_byte_t v;
    pcacc_byte_t w;
    logic [2:0]  en;
    logic        pol;
    logic        lvl;
    int          k;
    pcacc_top pcacc_top_i (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .SFR_ADDR(SFR_ADDR),
        .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RDATA(SFR_RDATA), .COUNTER(COUNTER),
        .COUNTER_TICK(COUNTER_TICK), .CMP_RESULT(CMP_RESULT), .RELOAD_VALUE(RELOAD_VALUE),
        .RELOAD_APPLY(RELOAD_APPLY), .CYCLE_LENGTH(CYCLE_LENGTH), .CH0_FREQ_MODE(CH0_FREQ_MODE),
        .CH0_WIDE_PWM(CH0_WIDE_PWM), .CH0_MODE(CH0_MODE), .CHAN_CLEAR(CHAN_CLEAR), .IRQ(IRQ));
    always #10 CORE_CLK = ~CORE_CLK;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic results;
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input pcacc_byte_t a, input pcacc_byte_t d);
        SFR_ADDR = a;
        SFR_WDATA = d;
        SFR_WE = 1'b1;
        @(posedge CORE_CLK);
        #2;
        SFR_WE = 1'b0;
        @(posedge CORE_CLK);
        #2;
    endtask
    function automatic logic [1:0] exp_len(input int code);
        return (code < 4) ? code[1:0] : 2'h0;
    endfunction
    function automatic logic [2:0] exp_clear(input logic l, input logic p, input logic [2:0] e);
        return (l == p) ? e : 3'h0;
    endfunction
    task automatic rd(input pcacc_byte_t a, input pcacc_byte_t e);
        SFR_ADDR = a;
        #1;
        chk(SFR_RDATA, e);
    endtask
    task automatic tick(input logic [15:0] c);
        COUNTER = c;
        COUNTER_TICK = 1'b1;
        @(posedge CORE_CLK);
        #2;
        COUNTER_TICK = 1'b0;
        @(posedge CORE_CLK);
        #2;
    endtask
    task automatic cmp_step(input logic l, input logic [2:0] exp);
        int i;
        CMP_RESULT = l;
        for (i = 0; i < 10 && CHAN_CLEAR === 3'h0; i++)
        begin
            @(posedge CORE_CLK);
            #2;
        end
        if (exp != 3'h0 && CHAN_CLEAR === 3'h0)
        begin
            bad_count++;
            results;
        end
        if (exp != 3'h0)
            chk(16'(i), 16'h0004);
        chk(CHAN_CLEAR, exp);
        @(posedge CORE_CLK);
        #2;
        chk(CHAN_CLEAR, 3'h0);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {CORE_CLK, RSTN, SFR_WE, COUNTER_TICK, CMP_RESULT} = 5'h00;
        {SFR_ADDR, SFR_WDATA, COUNTER} = 32'h0000_0000;
        bad_count = 0;
        n_compared = 0;
        seed = 53;
        repeat (10) @(posedge CORE_CLK);
        #2;
        RSTN = 1'b1;
        rd(8'h9C, 8'h00);
        rd(8'hDA, 8'h00);
        rd(8'hF7, 8'h00);
        chk({IRQ, CHAN_CLEAR}, 4'h0);
        wr(8'h55, 8'hA5);
        rd(8'h55, 8'h00);
        for (k = 0; k < 8; k++)
        begin
            v = 8'($random(seed));
            wr(8'hDA, v);
            chk(CH0_WIDE_PWM, v[7] & v[1]);
            rd(8'hDA, v);
            chk(CH0_MODE, v);
            chk(CH0_FREQ_MODE, v[2] & v[1]);
        end
        wr(8'hF7, 8'hC7);
        rd(8'hF7, 8'hC7);
        wr(8'h9C, 8'h87);
        rd(8'h9C, 8'h87);
        wr(8'hDA, 8'h02);
        for (k = 0; k < 8; k++)
        begin
            wr(8'hF7, k[7:0]);
            chk(CYCLE_LENGTH, exp_len(k));
            chk(RELOAD_APPLY, (k > 0 && k < 4));
        end
        wr(8'hF7, 8'h03);
        wr(8'hDA, 8'h82);
        chk({CH0_WIDE_PWM, CYCLE_LENGTH, RELOAD_APPLY}, 4'h8);
        wr(8'hDA, 8'h06);
        chk({CH0_FREQ_MODE, RELOAD_APPLY}, 2'h2);
        v = 8'($random(seed));
        w = 8'($random(seed));
        wr(8'hF7, 8'h00);
        wr(8'hFB, v);
        wr(8'hFC, w);
        wr(8'hF7, 8'h80);
        wr(8'hFB, ~v);
        wr(8'hFC, ~w);
        rd(8'hFB, ~v);
        rd(8'hFC, ~w);
        wr(8'hF7, 8'h00);
        rd(8'hFB, v);
        rd(8'hFC, w);
        chk(RELOAD_VALUE, {w, v});
        wr(8'hDA, 8'h02);
        wr(8'hF7, 8'h01);
        chk(RELOAD_APPLY, 1'b1);
        chk(RELOAD_VALUE, {~w, ~v});
        wr(8'hDA, 8'h00);
        for (k = 0; k < 4; k++)
        begin
            wr(8'hF7, 8'h40 | k[7:0]);
            tick((k == 0) ? 16'h0001 : (16'h0001 << (7 + k)));
            rd(8'hF7, 8'h40 | k[7:0]);
            chk(IRQ, 1'b0);
            tick(16'($random(seed)) << (8 + k));
            rd(8'hF7, 8'h60 | k[7:0]);
            chk(IRQ, 1'b1);
            tick(16'h0001);
            rd(8'hF7, 8'h60 | k[7:0]);
            wr(8'hF7, 8'h20 | k[7:0]);
            chk(IRQ, 1'b0);
            wr(8'hF7, k[7:0]);
            rd(8'hF7, k[7:0]);
        end
        wr(8'hF7, 8'h20);
        rd(8'hF7, 8'h20);
        wr(8'hF7, 8'h00);
        lvl = 1'b0;
        for (k = 0; k < 12; k++)
        begin
            en = (k < 2) ? 3'h7 : 3'($random(seed));
            pol = (k < 2) ? 1'b1 : 1'($random(seed));
            wr(8'h9C, {pol, 4'h0, en});
            lvl = ~lvl;
            cmp_step(lvl, exp_clear(lvl, pol, en));
        end
        wr(8'hF7, 8'h60);
        chk(IRQ, 1'b1);
        RSTN = 1'b0;
        @(posedge CORE_CLK);
        #2;
        chk({IRQ, CHAN_CLEAR, RELOAD_APPLY}, 5'h00);
        rd(8'hF7, 8'h00);
        rd(8'h9C, 8'h00);
        RSTN = 1'b1;
        wr(8'hDA, 8'hA6);
        rd(8'hDA, 8'hA6);
        results;
    end
    initial
    begin
        #1000000;
        bad_count++;
        results;
    end
endmodule

// ### verilog/pcacc_cfg_if.sv
// Interface carrying configuration from the register file to the clear logic.
`timescale 1ns/1ns
interface pcacc_cfg_if;
    logic       clear_pol;
    logic [2:0] clear_en;
    logic [2:0] clear_pulse;
    modport regs  (output clear_pol, output clear_en, input clear_pulse);
    modport clear (input clear_pol, input clear_en, output clear_pulse);
endinterface

// ### verilog/pcacc_cmp_clear.sv
// Comparator synchroniser and channel clear pulse generator.
`timescale 1ns/1ns
`include "pcacc_defs.svh"
module pcacc_cmp_clear
    import pcacc_pkg::*;
(
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // Comparator and configuration
    input  wire logic   cmp_in,
    pcacc_cfg_if.clear  cfg
);
    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic       level_reg;
    logic       level_next;
    logic [2:0] pulse_reg;
    logic [2:0] pulse_next;
    logic       changed;

    always_comb
    begin
        sync_next  = {sync_reg[1:0], cmp_in};
        level_next = level_reg;
        changed    = 1'b0;
        if (sync_reg[1] == sync_reg[2] && sync_reg[2] != level_reg)
        begin
            level_next = sync_reg[2];
            changed    = 1'b1;
        end
        pulse_next = 3'h0;
        if (changed && (sync_reg[2] == cfg.clear_pol))
        begin
            pulse_next = cfg.clear_en;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_reg  <= 3'h0;
            level_reg <= 1'b0;
            pulse_reg <= 3'h0;
        end
        else
        begin
            sync_reg  <= sync_next;
            level_reg <= level_next;
            pulse_reg <= pulse_next;
        end
    end

    assign cfg.clear_pulse = pulse_reg;

    property p_clear_pulse;
        @(posedge clk) disable iff (!rst_n)
        (sync_reg[1] == sync_reg[2] && sync_reg[2] != level_reg && sync_reg[2] == cfg.clear_pol)
        |=> (pulse_reg == $past(cfg.clear_en));
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse missing");

    property p_no_pulse_wrong_pol;
        @(posedge clk) disable iff (!rst_n)
        (pulse_reg != 3'h0) |-> ($past(sync_reg[2]) == $past(cfg.clear_pol));
    endproperty
    a_no_pulse_wrong_pol: assert property (p_no_pulse_wrong_pol) else $error("bad polarity");

    property p_pulse_single;
        @(posedge clk) disable iff (!rst_n)
        (pulse_reg != 3'h0) |=> (pulse_reg == 3'h0);
    endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("clear pulse too long");
endmodule

// ### verilog/pcacc_defs.svh
// Constants for the counter-array cycle configuration and comparator clear block.
`ifndef PCACC_DEFS_SVH
`define PCACC_DEFS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define PCACC_ADDR_CLR      8'h9C
`define PCACC_ADDR_MODE0    8'hDA
`define PCACC_ADDR_PWM      8'hF7
`define PCACC_ADDR_CPL0     8'hFB
`define PCACC_ADDR_CPH0     8'hFC
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PCACC_PWM_WSEL      7
`define PCACC_PWM_COVIE     6
`define PCACC_PWM_OVF       5
`define PCACC_PWM_LEN_MSB   2
`define PCACC_CLR_EN_MSB    2
`define PCACC_CLR_POL       7
`define PCACC_M_WIDE        7
`define PCACC_M_TOGGLE      2
`define PCACC_M_PWM         1
`define PCACC_PWM_RW_MASK   8'hE7
`define PCACC_CLR_RW_MASK   8'h87
`define PCACC_RESET_BYTE    8'h00
`endif

// ### verilog/pcacc_pkg.sv
// Types shared by the cycle configuration and comparator clear block.
package pcacc_pkg;
    typedef enum logic [1:0] {PCACC_LEN8, PCACC_LEN9, PCACC_LEN10, PCACC_LEN11} pcacc_len_e;
    typedef logic [7:0] pcacc_byte_t;
endpackage

// ### verilog/pcacc_top.sv
// Cycle configuration, overflow flag, reload window and comparator clear block.
`timescale 1ns/1ns
`include "pcacc_defs.svh"
module pcacc_top
    import pcacc_pkg::*;
(
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    // Register bus
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic [7:0]  SFR_WDATA,
    input  wire logic        SFR_WE,
    output logic      [7:0]  SFR_RDATA,
    // Counter and comparator
    input  wire logic [15:0] COUNTER,
    input  wire logic        COUNTER_TICK,
    input  wire logic        CMP_RESULT,
    // Channel side
    output logic      [15:0] RELOAD_VALUE,
    output logic             RELOAD_APPLY,
    output logic      [1:0]  CYCLE_LENGTH,
    output logic             CH0_FREQ_MODE,
    output logic             CH0_WIDE_PWM,
    output logic      [7:0]  CH0_MODE,
    output logic      [2:0]  CHAN_CLEAR,
    output logic             IRQ
);
    pcacc_cfg_if cfg ();

    pcacc_byte_t pwm_reg;
    pcacc_byte_t pwm_next;
    pcacc_byte_t clr_reg;
    pcacc_byte_t clr_next;
    pcacc_byte_t mode_reg;
    pcacc_byte_t mode_next;
    pcacc_byte_t cpl_reg;
    pcacc_byte_t cpl_next;
    pcacc_byte_t cph_reg;
    pcacc_byte_t cph_next;
    pcacc_byte_t arl_reg;
    pcacc_byte_t arl_next;
    pcacc_byte_t arh_reg;
    pcacc_byte_t arh_next;
    logic        ovf_event;
    pcacc_len_e  len;
    logic        pwm_wr;
    logic        mode_wr;
    logic        clr_wr;

    // ----------------------------------------
    // Cycle length decode
    // ----------------------------------------
    function automatic pcacc_len_e decode_len(input logic [2:0] sel);
        case (sel)
            3'h0:    decode_len = PCACC_LEN8;
            3'h1:    decode_len = PCACC_LEN9;
            3'h2:    decode_len = PCACC_LEN10;
            3'h3:    decode_len = PCACC_LEN11;
            default: decode_len = PCACC_LEN8;
        endcase
    endfunction

    assign len = decode_len(pwm_reg[`PCACC_PWM_LEN_MSB:0]);

    // Overflow of the watched counter bit: the low bits wrap to zero on a tick.
    always_comb
    begin
        case (len)
            PCACC_LEN8:  ovf_event = COUNTER_TICK && (COUNTER[7:0] == 8'h00);
            PCACC_LEN9:  ovf_event = COUNTER_TICK && (COUNTER[8:0] == 9'h000);
            PCACC_LEN10: ovf_event = COUNTER_TICK && (COUNTER[9:0] == 10'h000);
            PCACC_LEN11: ovf_event = COUNTER_TICK && (COUNTER[10:0] == 11'h000);
            default:     ovf_event = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_comb
    begin
        pwm_next  = pwm_reg;
        clr_next  = clr_reg;
        mode_next = mode_reg;
        cpl_next  = cpl_reg;
        cph_next  = cph_reg;
        arl_next  = arl_reg;
        arh_next  = arh_reg;
        if (SFR_WE)
        begin
            case (SFR_ADDR)
                `PCACC_ADDR_PWM:
                    pwm_next = SFR_WDATA & `PCACC_PWM_RW_MASK;
                `PCACC_ADDR_CLR:
                    clr_next = SFR_WDATA & `PCACC_CLR_RW_MASK;
                `PCACC_ADDR_MODE0:
                    mode_next = SFR_WDATA;
                `PCACC_ADDR_CPL0:
                begin
                    if (pwm_reg[`PCACC_PWM_WSEL])
                        arl_next = SFR_WDATA;
                    else
                        cpl_next = SFR_WDATA;
                end
                `PCACC_ADDR_CPH0:
                begin
                    if (pwm_reg[`PCACC_PWM_WSEL])
                        arh_next = SFR_WDATA;
                    else
                        cph_next = SFR_WDATA;
                end
                default:
                    pwm_next = pwm_reg;
            endcase
        end
        if (ovf_event)
        begin
            pwm_next[`PCACC_PWM_OVF] = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pwm_reg  <= `PCACC_RESET_BYTE;
            clr_reg  <= `PCACC_RESET_BYTE;
            mode_reg <= `PCACC_RESET_BYTE;
            cpl_reg  <= `PCACC_RESET_BYTE;
            cph_reg  <= `PCACC_RESET_BYTE;
            arl_reg  <= `PCACC_RESET_BYTE;
            arh_reg  <= `PCACC_RESET_BYTE;
        end
        else
        begin
            pwm_reg  <= pwm_next;
            clr_reg  <= clr_next;
            mode_reg <= mode_next;
            cpl_reg  <= cpl_next;
            cph_reg  <= cph_next;
            arl_reg  <= arl_next;
            arh_reg  <= arh_next;
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always_comb
    begin
        case (SFR_ADDR)
            `PCACC_ADDR_PWM:   SFR_RDATA = pwm_reg;
            `PCACC_ADDR_CLR:   SFR_RDATA = clr_reg;
            `PCACC_ADDR_MODE0: SFR_RDATA = mode_reg;
            `PCACC_ADDR_CPL0:  SFR_RDATA = pwm_reg[`PCACC_PWM_WSEL] ? arl_reg : cpl_reg;
            `PCACC_ADDR_CPH0:  SFR_RDATA = pwm_reg[`PCACC_PWM_WSEL] ? arh_reg : cph_reg;
            default:           SFR_RDATA = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Channel side outputs
    // ----------------------------------------
    assign IRQ           = pwm_reg[`PCACC_PWM_COVIE] & pwm_reg[`PCACC_PWM_OVF];
    assign CH0_MODE      = mode_reg;
    assign CH0_WIDE_PWM  = mode_reg[`PCACC_M_PWM] & mode_reg[`PCACC_M_WIDE];
    assign CH0_FREQ_MODE = mode_reg[`PCACC_M_PWM] & mode_reg[`PCACC_M_TOGGLE];
    assign CYCLE_LENGTH  = CH0_WIDE_PWM ? 2'h0 : len;
    assign RELOAD_APPLY  = mode_reg[`PCACC_M_PWM] & ~mode_reg[`PCACC_M_WIDE]
                         & ~mode_reg[`PCACC_M_TOGGLE] & (len != PCACC_LEN8);
    assign RELOAD_VALUE  = RELOAD_APPLY ? {arh_reg, arl_reg} : {cph_reg, cpl_reg};

    assign cfg.clear_pol = clr_reg[`PCACC_CLR_POL];
    assign cfg.clear_en  = clr_reg[`PCACC_CLR_EN_MSB:0];
    assign CHAN_CLEAR    = cfg.clear_pulse;

    pcacc_cmp_clear u_clear (
        .clk    (CORE_CLK),
        .rst_n  (RSTN),
        .cmp_in (CMP_RESULT),
        .cfg    (cfg.clear)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    assign pwm_wr  = SFR_WE && (SFR_ADDR == `PCACC_ADDR_PWM);
    assign mode_wr = SFR_WE && (SFR_ADDR == `PCACC_ADDR_MODE0);
    assign clr_wr  = SFR_WE && (SFR_ADDR == `PCACC_ADDR_CLR);

    property p_flag_sets;
        @(posedge CORE_CLK) disable iff (!RSTN)
        ovf_event |=> pwm_reg[`PCACC_PWM_OVF];
    endproperty
    a_flag_sets: assert property (p_flag_sets) else $error("overflow flag not set");

    property p_flag_sticky;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (pwm_reg[`PCACC_PWM_OVF] && !pwm_wr)
        |=> pwm_reg[`PCACC_PWM_OVF];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

    property p_irq;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (ovf_event && pwm_reg[`PCACC_PWM_COVIE] && !pwm_wr) |=> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch");

    property p_window;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (SFR_WE && SFR_ADDR == `PCACC_ADDR_CPL0 && pwm_reg[`PCACC_PWM_WSEL])
        |=> (arl_reg == $past(SFR_WDATA)) && $stable(cpl_reg);
    endproperty
    a_window: assert property (p_window) else $error("reload window write wrong");

    property p_mode_write;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (SFR_WE && SFR_ADDR == `PCACC_ADDR_MODE0) |=> CH0_MODE == $past(SFR_WDATA);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");

    property p_reload_apply;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (len == PCACC_LEN8 || !mode_reg[`PCACC_M_PWM]) |-> !RELOAD_APPLY;
    endproperty
    a_reload_apply: assert property (p_reload_apply) else $error("reload in wrong mode");

    property p_irq_off;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (pwm_wr && !SFR_WDATA[`PCACC_PWM_COVIE]) |=> !IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("masked interrupt");

    property p_flag_rise;
        @(posedge CORE_CLK) disable iff (!RSTN)
        $rose(pwm_reg[`PCACC_PWM_OVF])
        |-> $past(COUNTER_TICK) || ($past(pwm_wr) && $past(SFR_WDATA[`PCACC_PWM_OVF]));
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag set without cause");

    property p_flag_fall;
        @(posedge CORE_CLK) disable iff (!RSTN)
        $fell(pwm_reg[`PCACC_PWM_OVF])
        |-> $past(pwm_wr) && !$past(SFR_WDATA[`PCACC_PWM_OVF]);
    endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("flag fell");

    property p_sw_clear;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (pwm_wr && !SFR_WDATA[`PCACC_PWM_OVF] && !ovf_event) |=> !pwm_reg[`PCACC_PWM_OVF];
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("flag clear lost");

    property p_pwm_hold;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (!pwm_wr && !ovf_event) |=> $stable(pwm_reg);
    endproperty
    a_pwm_hold: assert property (p_pwm_hold) else $error("config changed");

    property p_len_map;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (pwm_wr && !SFR_WDATA[`PCACC_PWM_LEN_MSB] && !CH0_WIDE_PWM)
        |=> (CYCLE_LENGTH == $past(SFR_WDATA[1:0]));
    endproperty
    a_len_map: assert property (p_len_map) else $error("cycle length wrong");

    property p_len_resv;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (pwm_wr && SFR_WDATA[`PCACC_PWM_LEN_MSB]) |=> (CYCLE_LENGTH == 2'h0);
    endproperty
    a_len_resv: assert property (p_len_resv) else $error("reserved length");

    property p_wide_len;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (mode_wr && SFR_WDATA[`PCACC_M_WIDE] && SFR_WDATA[`PCACC_M_PWM])
        |=> CH0_WIDE_PWM && (CYCLE_LENGTH == 2'h0) && !RELOAD_APPLY;
    endproperty
    a_wide_len: assert property (p_wide_len) else $error("wide mode length");

    property p_freq;
        @(posedge CORE_CLK) disable iff (!RSTN)
        mode_wr |=> (CH0_FREQ_MODE == ($past(SFR_WDATA[`PCACC_M_TOGGLE])
                                        && $past(SFR_WDATA[`PCACC_M_PWM])));
    endproperty
    a_freq: assert property (p_freq) else $error("frequency mode wrong");

    property p_cmp_window;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (SFR_WE && SFR_ADDR == `PCACC_ADDR_CPH0 && !pwm_reg[`PCACC_PWM_WSEL])
        |=> (cph_reg == $past(SFR_WDATA)) && $stable(arh_reg);
    endproperty
    a_cmp_window: assert property (p_cmp_window) else $error("compare write wrong");

    property p_reload_off;
        @(posedge CORE_CLK) disable iff (!RSTN)
        (!RELOAD_APPLY && SFR_WE && SFR_ADDR == `PCACC_ADDR_CPL0 && pwm_reg[`PCACC_PWM_WSEL])
        |=> $stable(RELOAD_VALUE);
    endproperty
    a_reload_off: assert property (p_reload_off) else $error("reload leaked");

    property p_mode_hold;
        @(posedge CORE_CLK) disable iff (!RSTN)
        !mode_wr |=> $stable(CH0_MODE);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

    property p_clear_cfg;
        @(posedge CORE_CLK) disable iff (!RSTN)
        clr_wr |=> (cfg.clear_en == $past(SFR_WDATA[`PCACC_CLR_EN_MSB:0]))
                   && (cfg.clear_pol == $past(SFR_WDATA[`PCACC_CLR_POL]));
    endproperty
    a_clear_cfg: assert property (p_clear_cfg) else $error("clear config wrong");
endmodule
